// ---- bst_cfg.svh ----
// Constants for the tone burst generator: offsets, fields, reset values, gains
`ifndef BST_CFG_SVH
`define BST_CFG_SVH
// ======================================================================
// Register offsets
`define BST_ADDR_LCTL 7'h47
`define BST_ADDR_RCTL 7'h48
`define BST_ADDR_LEN_H 7'h49
`define BST_ADDR_LEN_M 7'h4a
`define BST_ADDR_LEN_L 7'h4b
`define BST_ADDR_SIN_H 7'h4c
`define BST_ADDR_SIN_L 7'h4d
`define BST_ADDR_COS_H 7'h4e
`define BST_ADDR_COS_L 7'h4f
// ======================================================================
// Field positions
`define BST_TRIG_BIT 7
`define BST_MST_HI 7
`define BST_MST_LO 6
`define BST_VOL_HI 5
`define BST_VOL_LO 0
`define BST_MST_BY_LEFT 2'h1
`define BST_MST_BY_RIGHT 2'h2
// ======================================================================
// Reset values
`define BST_RST_LEN_H 8'h00
`define BST_RST_LEN_M 8'h00
`define BST_RST_LEN_L 8'hee
`define BST_RST_SIN_H 8'h10
`define BST_RST_SIN_L 8'hd8
`define BST_RST_COS_H 8'h7e
`define BST_RST_COS_L 8'he3
`define BST_RST_VOL 6'h00
`define BST_RST_MST 2'h0
`define BST_ZERO8 8'h00
`define BST_ZERO16 16'h0000
`define BST_LEN_ZERO 24'h000000
`define BST_LEN_ONE 24'h000001
// ======================================================================
// Arithmetic
`define BST_OSC_SHIFT 14
`define BST_GAIN_SHIFT 14
`define BST_DB_PER_HALF 6'h06
`define BST_S16_MAX 16'h7fff
`define BST_S16_MIN 16'h8000
`define BST_GAIN_P2 16'h5092
`define BST_GAIN_P1 16'h47cf
`define BST_GAIN_0 16'h4000
`define BST_GAIN_M1 16'h390a
`define BST_GAIN_M2 16'h32d6
`define BST_GAIN_M3 16'h2d4f
`endif

// ---- bst_pkg.sv ----
// Types shared by the tone burst generator modules
package bst_pkg;
   typedef enum logic [0:0] {
      BST_IDLE = 1'b0,
      BST_RUN = 1'b1
   } bst_state_t;

   typedef struct packed {
      logic signed [15:0] cur;
      logic signed [15:0] prev;
   } bst_osc_st_t;

   typedef struct packed {
      logic signed [15:0] sample;
      logic valid;
   } bst_vol_st_t;

   typedef struct packed {
      bst_state_t state;
      logic [23:0] cnt;
      logic [5:0] lvol;
      logic [5:0] rvol;
      logic [1:0] master;
      logic [7:0] len_h;
      logic [7:0] len_m;
      logic [7:0] len_l;
      logic [7:0] sin_h;
      logic [7:0] sin_l;
      logic [7:0] cos_h;
      logic [7:0] cos_l;
      logic [7:0] rdata;
      logic signed [15:0] play_l;
      logic signed [15:0] play_r;
      logic signed [15:0] mix_l;
      logic signed [15:0] mix_r;
      logic mix_valid;
   } bst_top_st_t;
endpackage

// ---- bst_osc.sv ----
// Recursive sine oscillator advanced once per sample period
`timescale 1ns/1ps
`include "bst_cfg.svh"
module bst_osc import bst_pkg::*; (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic restart_in,
   input wire logic step_in,
   input wire logic [15:0] sin_coef_in,
   input wire logic [15:0] cos_coef_in,
   output logic [15:0] sample_out
);
   bst_osc_st_t s_reg;
   bst_osc_st_t s_next;
   logic signed [31:0] prod;
   logic signed [33:0] sum;

   // ======================================================================
   // Next sample: 2*cos*y[n-1] - y[n-2], saturated to 16 bits
   always_comb begin
      s_next = s_reg;
      prod = $signed(cos_coef_in) * s_reg.cur;
      sum = 34'(prod >>> `BST_OSC_SHIFT) - 34'(s_reg.prev);
      if (restart_in) begin
         // Phase starts at zero so the burst opens without a click
         s_next.cur = `BST_ZERO16;
         s_next.prev = 16'(`BST_ZERO16 - sin_coef_in);
      end else if (step_in) begin
         s_next.prev = s_reg.cur;
         if (sum > 34'sd32767) begin
            s_next.cur = `BST_S16_MAX;
         end else if (sum < -34'sd32768) begin
            s_next.cur = `BST_S16_MIN;
         end else begin
            s_next.cur = sum[15:0];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s_reg.cur <= `BST_ZERO16;
         s_reg.prev <= `BST_ZERO16;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sample_out = s_reg.cur;

   // ======================================================================
   // Checks
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence restart_seq;
      restart_in ##1 (sample_out == `BST_ZERO16);
   endsequence

   chk_osc_first_step: assert property (
      (restart_in ##1 (step_in && !restart_in)) |=> (sample_out == $past(sin_coef_in, 2)))
      else $error("first oscillator step is not the sine coefficient");
   chk_osc_restart_zero: assert property (restart_in |-> restart_seq)
      else $error("oscillator phase not cleared at restart");
   chk_osc_hold: assert property (!restart_in && !step_in |=> $stable(sample_out))
      else $error("oscillator moved without a sample tick");
endmodule

// ---- bst_vol.sv ----
// Tone level stage: 6-bit code, +2 dB down to -61 dB in 1 dB steps
`timescale 1ns/1ps
`include "bst_cfg.svh"
module bst_vol import bst_pkg::*; (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic valid_in,
   input wire logic [15:0] sample_in,
   input wire logic [5:0] level_in,
   output logic valid_out,
   output logic [15:0] sample_out
);
   bst_vol_st_t s_reg;
   bst_vol_st_t s_next;
   logic [5:0] octaves;
   logic [5:0] fine;
   logic [15:0] gain;
   logic signed [32:0] prod;
   logic signed [32:0] scaled;

   // ======================================================================
   // Six codes make one halving; the remainder picks a fine gain
   always_comb begin
      s_next = s_reg;
      octaves = level_in / `BST_DB_PER_HALF;
      fine = level_in % `BST_DB_PER_HALF;
      case (fine[2:0])
         3'h0: gain = `BST_GAIN_P2;
         3'h1: gain = `BST_GAIN_P1;
         3'h2: gain = `BST_GAIN_0;
         3'h3: gain = `BST_GAIN_M1;
         3'h4: gain = `BST_GAIN_M2;
         default: gain = `BST_GAIN_M3;
      endcase
      prod = $signed(sample_in) * $signed({1'b0, gain});
      scaled = prod >>> (`BST_GAIN_SHIFT + 32'(octaves));
      s_next.valid = valid_in;
      if (valid_in) begin
         // The +2 dB step can exceed full scale, so clip
         if (scaled > 33'sd32767) begin
            s_next.sample = `BST_S16_MAX;
         end else if (scaled < -33'sd32768) begin
            s_next.sample = `BST_S16_MIN;
         end else begin
            s_next.sample = scaled[15:0];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s_reg.sample <= `BST_ZERO16;
         s_reg.valid <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign valid_out = s_reg.valid;
   assign sample_out = s_reg.sample;

   // ======================================================================
   // Checks
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   chk_vol_latency: assert property (valid_in |=> valid_out)
      else $error("scaled sample not produced one cycle after input");
   chk_vol_zero_in: assert property (valid_in && sample_in == `BST_ZERO16 |=>
      sample_out == `BST_ZERO16)
      else $error("silence did not stay silent through the level stage");
   chk_vol_unity: assert property (valid_in && level_in == 6'h02 |=>
      sample_out == $past(sample_in))
      else $error("0 dB code did not pass the sample unchanged");
endmodule

// ---- bst_top.sv ----
// Tone burst generator: register bank, burst control, level and mixer
// ======================================================================
`timescale 1ns/1ps
`include "bst_cfg.svh"
module bst_top import bst_pkg::*; (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   input wire logic sample_tick_in,
   input wire logic [15:0] play_left_in,
   input wire logic [15:0] play_right_in,
   output logic [15:0] mix_left_out,
   output logic [15:0] mix_right_out,
   output logic mix_valid_out,
   output logic tone_busy_out
);
   bst_top_st_t s_reg;
   bst_top_st_t s_next;
   logic trig_wr;
   logic osc_step;
   logic [15:0] osc_sample;
   logic [15:0] tone_sample;
   logic [5:0] lvl_left;
   logic [5:0] lvl_right;
   logic vl_valid;
   logic vr_valid;
   logic [15:0] vl_sample;
   logic [15:0] vr_sample;
   logic signed [16:0] sum_l;
   logic signed [16:0] sum_r;

   // ======================================================================
   // Oscillator and level stages
   assign trig_wr = reg_wr_in && reg_addr_in == `BST_ADDR_LCTL
      && reg_wdata_in[`BST_TRIG_BIT];
   assign osc_step = sample_tick_in && s_reg.state == BST_RUN && !trig_wr;

   bst_osc u_osc (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .restart_in(trig_wr),
      .step_in(osc_step),
      .sin_coef_in({s_reg.sin_h, s_reg.sin_l}),
      .cos_coef_in({s_reg.cos_h, s_reg.cos_l}),
      .sample_out(osc_sample)
   );

   // A zero-length burst ends on its first tick and plays nothing
   assign tone_sample = (s_reg.state == BST_RUN && s_reg.cnt != `BST_LEN_ZERO) ?
      osc_sample : `BST_ZERO16;

   always_comb begin
      lvl_left = s_reg.lvol;
      lvl_right = s_reg.rvol;
      case (s_reg.master)
         `BST_MST_BY_LEFT: lvl_right = s_reg.lvol;
         `BST_MST_BY_RIGHT: lvl_left = s_reg.rvol;
         default: lvl_left = s_reg.lvol;
      endcase
   end

   bst_vol u_vol_l (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .valid_in(sample_tick_in),
      .sample_in(tone_sample),
      .level_in(lvl_left),
      .valid_out(vl_valid),
      .sample_out(vl_sample)
   );

   bst_vol u_vol_r (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .valid_in(sample_tick_in),
      .sample_in(tone_sample),
      .level_in(lvl_right),
      .valid_out(vr_valid),
      .sample_out(vr_sample)
   );

   // ======================================================================
   // Register writes, burst control, read path and mixer
   always_comb begin
      s_next = s_reg;
      s_next.mix_valid = 1'b0;
      sum_l = 17'(s_reg.play_l) + 17'($signed(vl_sample));
      sum_r = 17'(s_reg.play_r) + 17'($signed(vr_sample));
      if (reg_wr_in) begin
         case (reg_addr_in)
            `BST_ADDR_LCTL: s_next.lvol = reg_wdata_in[`BST_VOL_HI:`BST_VOL_LO];
            `BST_ADDR_RCTL: begin
               s_next.rvol = reg_wdata_in[`BST_VOL_HI:`BST_VOL_LO];
               s_next.master = reg_wdata_in[`BST_MST_HI:`BST_MST_LO];
            end
            `BST_ADDR_LEN_H: s_next.len_h = reg_wdata_in;
            `BST_ADDR_LEN_M: s_next.len_m = reg_wdata_in;
            `BST_ADDR_LEN_L: s_next.len_l = reg_wdata_in;
            `BST_ADDR_SIN_H: s_next.sin_h = reg_wdata_in;
            `BST_ADDR_SIN_L: s_next.sin_l = reg_wdata_in;
            `BST_ADDR_COS_H: s_next.cos_h = reg_wdata_in;
            `BST_ADDR_COS_L: s_next.cos_l = reg_wdata_in;
            default: s_next.rdata = s_reg.rdata;
         endcase
      end
      // A fresh trigger wins over the end of a running burst
      if (trig_wr) begin
         s_next.state = BST_RUN;
         s_next.cnt = {s_reg.len_h, s_reg.len_m, s_reg.len_l};
      end else if (sample_tick_in && s_reg.state == BST_RUN) begin
         if (s_reg.cnt <= `BST_LEN_ONE) begin
            s_next.state = BST_IDLE;
            s_next.cnt = `BST_LEN_ZERO;
         end else begin
            s_next.cnt = s_reg.cnt - `BST_LEN_ONE;
         end
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            `BST_ADDR_LCTL: s_next.rdata = {s_reg.state == BST_RUN, 1'b0, s_reg.lvol};
            `BST_ADDR_RCTL: s_next.rdata = {s_reg.master, s_reg.rvol};
            `BST_ADDR_LEN_H: s_next.rdata = s_reg.len_h;
            `BST_ADDR_LEN_M: s_next.rdata = s_reg.len_m;
            `BST_ADDR_LEN_L: s_next.rdata = s_reg.len_l;
            `BST_ADDR_SIN_H: s_next.rdata = s_reg.sin_h;
            `BST_ADDR_SIN_L: s_next.rdata = s_reg.sin_l;
            `BST_ADDR_COS_H: s_next.rdata = s_reg.cos_h;
            `BST_ADDR_COS_L: s_next.rdata = s_reg.cos_l;
            default: s_next.rdata = `BST_ZERO8;
         endcase
      end
      // Playback arrives already volume set, so its control never scales the tone
      if (sample_tick_in) begin
         s_next.play_l = play_left_in;
         s_next.play_r = play_right_in;
      end
      if (vl_valid && vr_valid) begin
         s_next.mix_valid = 1'b1;
         if (sum_l > 17'sd32767) begin
            s_next.mix_l = `BST_S16_MAX;
         end else if (sum_l < -17'sd32768) begin
            s_next.mix_l = `BST_S16_MIN;
         end else begin
            s_next.mix_l = sum_l[15:0];
         end
         if (sum_r > 17'sd32767) begin
            s_next.mix_r = `BST_S16_MAX;
         end else if (sum_r < -17'sd32768) begin
            s_next.mix_r = `BST_S16_MIN;
         end else begin
            s_next.mix_r = sum_r[15:0];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s_reg.state <= BST_IDLE;
         s_reg.cnt <= `BST_LEN_ZERO;
         s_reg.lvol <= `BST_RST_VOL;
         s_reg.rvol <= `BST_RST_VOL;
         s_reg.master <= `BST_RST_MST;
         s_reg.len_h <= `BST_RST_LEN_H;
         s_reg.len_m <= `BST_RST_LEN_M;
         s_reg.len_l <= `BST_RST_LEN_L;
         s_reg.sin_h <= `BST_RST_SIN_H;
         s_reg.sin_l <= `BST_RST_SIN_L;
         s_reg.cos_h <= `BST_RST_COS_H;
         s_reg.cos_l <= `BST_RST_COS_L;
         s_reg.rdata <= `BST_ZERO8;
         s_reg.play_l <= `BST_ZERO16;
         s_reg.play_r <= `BST_ZERO16;
         s_reg.mix_l <= `BST_ZERO16;
         s_reg.mix_r <= `BST_ZERO16;
         s_reg.mix_valid <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata_out = s_reg.rdata;
   assign mix_left_out = s_reg.mix_l;
   assign mix_right_out = s_reg.mix_r;
   assign mix_valid_out = s_reg.mix_valid;
   assign tone_busy_out = s_reg.state;

   // ======================================================================
   // Checks
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence last_tick_seq;
      s_reg.state == BST_RUN && sample_tick_in && s_reg.cnt <= `BST_LEN_ONE && !trig_wr;
   endsequence

   // A quiet tick sums playback with zero, so the mix must equal the input
   sequence idle_tick_seq;
      sample_tick_in && !tone_busy_out;
   endsequence

   sequence quiet_mix_seq;
      mix_valid_out && mix_left_out == $past(play_left_in, 2) &&
         mix_right_out == $past(play_right_in, 2);
   endsequence

   // Writing the level with the trigger bit low must not cut a running burst
   sequence clear_wr_seq;
      tone_busy_out && reg_wr_in && reg_addr_in == `BST_ADDR_LCTL &&
         !reg_wdata_in[`BST_TRIG_BIT] && !(sample_tick_in && s_reg.cnt <= `BST_LEN_ONE);
   endsequence

   chk_trig_start: assert property (trig_wr |=> tone_busy_out)
      else $error("trigger write did not start a burst");
   chk_self_clear: assert property (last_tick_seq |=> !tone_busy_out)
      else $error("trigger bit not cleared at end of burst");
   chk_len_load: assert property (trig_wr |=>
      s_reg.cnt == {$past(s_reg.len_h), $past(s_reg.len_m), $past(s_reg.len_l)})
      else $error("length counter not reloaded on trigger");
   chk_len_count: assert property (osc_step && s_reg.cnt > `BST_LEN_ONE |=>
      s_reg.cnt == $past(s_reg.cnt) - `BST_LEN_ONE && tone_busy_out)
      else $error("burst counter did not step once per sample");
   chk_reset_defaults: assert property ($past(sys_rst_in) |->
      {s_reg.len_h, s_reg.len_m, s_reg.len_l} == 24'h0000ee &&
      {s_reg.sin_h, s_reg.sin_l} == 16'h10d8 && {s_reg.cos_h, s_reg.cos_l} == 16'h7ee3 &&
      s_reg.lvol == 6'h00 && s_reg.rvol == 6'h00)
      else $error("reset values wrong");
   chk_idle_silent: assert property (idle_tick_seq |=> vl_sample == `BST_ZERO16 &&
      vr_sample == `BST_ZERO16)
      else $error("tone present while idle");
   chk_read_busy: assert property (reg_rd_in && reg_addr_in == `BST_ADDR_LCTL |=>
      reg_rdata_out[`BST_TRIG_BIT] == $past(tone_busy_out))
      else $error("trigger bit readback wrong");
   chk_master_tie: assert property (s_reg.master == `BST_MST_BY_LEFT |->
      lvl_right == s_reg.lvol)
      else $error("master tie did not copy the left level");
   chk_mix_latency: assert property (sample_tick_in ##1 !sample_tick_in |=>
      mix_valid_out && (mix_left_out == 16'($past(s_reg.play_l) + $past(vl_sample)) ||
      mix_left_out == `BST_S16_MAX || mix_left_out == `BST_S16_MIN))
      else $error("mixed sample missing or not the sum");

   // ======================================================================
   // Register, burst and mixer checks
   chk_left_write: assert property (reg_wr_in && reg_addr_in == `BST_ADDR_LCTL |=>
      s_reg.lvol == $past(reg_wdata_in[`BST_VOL_HI:`BST_VOL_LO]))
      else $error("left level write did not land");
   chk_sine_write: assert property (reg_wr_in && reg_addr_in == `BST_ADDR_SIN_L |=>
      {s_reg.sin_h, s_reg.sin_l} == {$past(s_reg.sin_h), $past(reg_wdata_in)})
      else $error("sine low byte write did not land");
   chk_cosine_write: assert property (reg_wr_in && reg_addr_in == `BST_ADDR_COS_H |=>
      {s_reg.cos_h, s_reg.cos_l} == {$past(reg_wdata_in), $past(s_reg.cos_l)})
      else $error("cosine high byte write did not land");
   chk_len_write: assert property (reg_wr_in && reg_addr_in == `BST_ADDR_LEN_M |=>
      s_reg.len_m == $past(reg_wdata_in) && s_reg.len_h == $past(s_reg.len_h))
      else $error("length middle byte write did not land");
   chk_len_low_write: assert property (reg_wr_in && reg_addr_in == `BST_ADDR_LEN_L |=>
      s_reg.len_l == $past(reg_wdata_in))
      else $error("length low byte write did not land");
   chk_right_write: assert property (reg_wr_in && reg_addr_in == `BST_ADDR_RCTL |=>
      {s_reg.master, s_reg.rvol} == $past(reg_wdata_in))
      else $error("right control write did not land");
   chk_read_right: assert property (reg_rd_in && reg_addr_in == `BST_ADDR_RCTL |=>
      reg_rdata_out == {$past(s_reg.master), $past(s_reg.rvol)})
      else $error("right control readback wrong");
   chk_right_tie: assert property (s_reg.master == `BST_MST_BY_RIGHT |->
      lvl_left == s_reg.rvol && lvl_right == s_reg.rvol)
      else $error("master tie did not copy the right level");
   chk_no_abort: assert property (clear_wr_seq |=> tone_busy_out)
      else $error("level write with trigger low stopped a burst");
   chk_mix_idle: assert property (idle_tick_seq |-> ##2 quiet_mix_seq)
      else $error("idle sample did not pass playback unchanged");
   chk_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");
   chk_unmapped_read: assert property (reg_rd_in && reg_addr_in > `BST_ADDR_COS_L |=>
      reg_rdata_out == `BST_ZERO8)
      else $error("unmapped read did not return zero");
   chk_mix_tick: assert property (mix_valid_out |-> $past(sample_tick_in, 2))
      else $error("mixed sample without a sample tick");
   chk_busy_needs_trig: assert property ($rose(tone_busy_out) |-> $past(trig_wr))
      else $error("burst started without a trigger write");
   chk_end_count_zero: assert property ($fell(tone_busy_out) |-> s_reg.cnt == `BST_LEN_ZERO)
      else $error("length counter not cleared at end of burst");
endmodule

// ---- bst_play_src.sv ----
// Playback stream source feeding the tone mixer
`timescale 1ns/1ps
module bst_play_src #(
   parameter int GAP = 6
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   output logic tick_out,
   output logic [15:0] play_left_out,
   output logic [15:0] play_right_out
);
   // ======================================================================
   // Sample pacing
   // A gap of six keeps ticks clear of the three-cycle minimum
   int cnt;
   initial begin
      cnt = 0;
      tick_out = 1'b0;
      play_left_out = 16'h0000;
      play_right_out = 16'h0000;
   end
   always @(posedge core_clk_in) begin
      #1;
      if (sys_rst_in) begin
         cnt = 0;
      end else begin
         cnt = cnt + 1;
      end
      // One assignment per edge keeps the tick free of zero-time glitches
      tick_out <= (cnt == GAP);
      if (cnt == GAP) begin
         cnt = 0;
         // Samples arrive already volume scaled and hold until the next tick
         play_left_out <= 16'($urandom);
         play_right_out <= 16'($urandom);
      end
   end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the tone burst generator
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module testbench;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [6:0] reg_addr_in = 7'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [7:0] reg_rdata_out;
   logic sample_tick_in;
   logic [15:0] play_left_in;
   logic [15:0] play_right_in;
   logic [15:0] mix_left_out;
   logic [15:0] mix_right_out;
   logic mix_valid_out;
   logic tone_busy_out;
   int fails = 0;
   int n_tests = 0;
   logic [15:0] y0;
   logic [15:0] y1;

   always #20 core_clk_in = ~core_clk_in;

   bst_top u_bst_top (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sample_tick_in(sample_tick_in),
      .play_left_in(play_left_in), .play_right_in(play_right_in),
      .mix_left_out(mix_left_out), .mix_right_out(mix_right_out),
      .mix_valid_out(mix_valid_out), .tone_busy_out(tone_busy_out));

   bst_play_src u_bst_play_src (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .tick_out(sample_tick_in), .play_left_out(play_left_in),
      .play_right_out(play_right_in));

   // ======================================================================
   // Bus and wait tasks
   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      reg_wr_in = 1'b0;
      // Let an edge pass so back-to-back writes never rewrite the strobe in one step
      @(posedge core_clk_in);
      #1;
   endtask

   task automatic reg_rd(input logic [6:0] a, output logic [7:0] d);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      reg_rd_in = 1'b0;
      @(posedge core_clk_in);
      #1;
      d = reg_rdata_out;
   endtask

   task automatic wait_mix();
      for (int i = 0; i < 40; i++) begin
         @(posedge core_clk_in);
         #1;
         if (mix_valid_out === 1'b1) begin
            return;
         end
      end
      fails++;
      $display("[ERR] %0t no mix pulse", $time);
      results();
   endtask

   // ======================================================================
   // Expected values
   function automatic logic [15:0] sat16(input longint v);
      if (v > 32767) begin
         return 16'h7fff;
      end
      if (v < -32768) begin
         return 16'h8000;
      end
      return 16'(v);
   endfunction

   // Only codes 2, 8, 14 and 20 are used, where the level is an exact shift
   function automatic logic [15:0] mix_exp(input logic [15:0] p, input logic [15:0] t,
                                           input int code);
      return sat16(longint'($signed(p)) + longint'($signed(t) >>> ((code - 2) / 6)));
   endfunction

   function automatic logic [15:0] osc_step(input logic [15:0] c);
      logic [15:0] t;
      t = y1;
      y1 = sat16(((longint'($signed(c)) * $signed(y1)) >>> 14) - longint'($signed(y0)));
      y0 = t;
      return t;
   endfunction

   // ======================================================================
   // Main sequence
   initial begin
      logic [7:0] d;
      logic [7:0] rv [9];
      logic [23:0] lens [5];
      logic [15:0] sn;
      logic [15:0] cs;
      logic [15:0] tn;
      logic [1:0] ms;
      int lc;
      int rc;
      int el;
      int er;
      int k;
      void'($urandom(32'h29032ef4));
      repeat (16) @(posedge core_clk_in);
      #1;
      sys_rst_in = 1'b0;
      `CHK(tone_busy_out, 1'b0)
      // First request waits one edge after reset is seen low
      @(posedge core_clk_in);
      #1;
      rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h10, 8'hd8, 8'h7e, 8'he3};
      for (k = 0; k < 9; k++) begin
         reg_rd(7'(7'h47 + k), d);
         `CHK(d, rv[k])
      end
      for (k = 1; k < 9; k++) begin
         d = 8'($urandom);
         reg_wr(7'(7'h47 + k), d);
         reg_rd(7'(7'h47 + k), rv[k]);
         `CHK(rv[k], d)
      end
      reg_wr(7'h47, 8'h7f);
      `CHK(tone_busy_out, 1'b0)
      reg_rd(7'h47, d);
      `CHK(d, 8'h3f)
      reg_wr(7'h50, 8'h5a);
      reg_rd(7'h50, d);
      `CHK(d, 8'h00)
      // Mid byte of the length gets its own burst; the top byte would run too long
      lens = '{24'h000001, 24'h000000, 24'h000100, 24'h000002, 24'h000005};
      lens[3] = 24'(2 + $urandom % 5);
      for (int b = 0; b < 5; b++) begin
         ms = 2'(b);
         lc = 2 + 6 * ($urandom % 4);
         rc = 2 + 6 * ($urandom % 4);
         sn = 16'($urandom % 4096);
         cs = 16'(16'h4000 + $urandom % 12288);
         el = (ms == 2'h2) ? rc : lc;
         er = (ms == 2'h1) ? lc : rc;
         reg_wr(7'h48, {ms, 6'(rc)});
         reg_wr(7'h49, lens[b][23:16]);
         reg_wr(7'h4a, lens[b][15:8]);
         reg_wr(7'h4b, lens[b][7:0]);
         reg_wr(7'h4c, sn[15:8]);
         reg_wr(7'h4d, sn[7:0]);
         reg_wr(7'h4e, cs[15:8]);
         reg_wr(7'h4f, cs[7:0]);
         wait_mix();
         if (b >= 2) begin
            // Trigger one cycle before a tick, on a tick, then clear of it
            repeat (b + 1) @(posedge core_clk_in);
            #1;
         end
         reg_wr(7'h47, {2'b10, 6'(lc)});
         `CHK(tone_busy_out, 1'b1)
         y1 = 16'h0000;
         y0 = 16'(-$signed(sn));
         k = 0;
         while (k < 300) begin
            wait_mix();
            tn = osc_step(cs);
            `CHK(mix_left_out, mix_exp(play_left_in, tn, el))
            `CHK(mix_right_out, mix_exp(play_right_in, tn, er))
            k++;
            if (k == 1) begin
               reg_wr(7'h47, {2'b00, 6'(lc)});
            end
            if (tone_busy_out !== 1'b1) begin
               break;
            end
         end
         `CHK(k, (lens[b] == 24'h000000) ? 1 : int'(lens[b]))
         wait_mix();
         `CHK(mix_left_out, play_left_in)
         `CHK(mix_right_out, play_right_in)
         reg_rd(7'h47, d);
         `CHK(d, {2'b00, 6'(lc)})
      end
      results();
   end
endmodule
